/* logic/psx_slot_regs.sv */
// Slot status word and second-generation device / link / slot register bank
`default_nettype none
// Overview of operation
// - Slot status only downstream, upper half D8h
// - Bit 16 button pressed, write-one clears
// - Bit 17 power fault, W1C, resets zero
// - Bit 18 latch changed read-only zero
// - Bit 19 presence changed, write-one clears
// - Bit 20 command completed, write-one clears
// - Bit 21 latch state, one means opened
// - Bit 22 card presence, one present
// - No slot implemented: presence reads one
// - Presence resets to inverse of strap
// - Bit 24 link-active change flag, W1C
// - Device cap 2 bit 11 reads one
// - Buffer flush support field resets 01b
// - LTR enable, flush enable writable, zero reset
// - De-emphasis select read-only, port dependent
// - Current de-emphasis level, port dependent
// - Interrupt needs event and global enable
module psx_slot_regs (
	input  wire logic                                    clk_in,
	input  wire logic                                    reset_in,
	input  wire logic                                    clk_en_in,
	input  wire logic                                    downstream_in,
	input  wire logic                                    slot_impl_in,
	input  wire logic                                    presence_strap_in,
	input  wire logic                                    card_present_in,
	input  wire logic                                    retention_latch_open_in,
	input  wire logic                                    button_event_in,
	input  wire logic                                    pwr_fault_event_in,
	input  wire logic                                    cmd_done_event_in,
	input  wire logic                                    link_active_in,
	input  wire logic [15:0]                             slot_ctrl_in,
	input  wire psx_regs_pkg::psx_cfg_req_t              cfg_req_in,
	output logic [31:0]                                  cfg_rdata_out,
	output logic                                         cfg_rvalid_out,
	output logic                                         ltr_en_out,
	output logic [1:0]                                   obff_en_out,
	output logic                                         hp_int_out
);
	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	logic        wr_slot;
	logic        wr_dctl;
	logic [31:0] w1c;
	logic        dn_port;
	assign dn_port = downstream_in;
	assign wr_slot = cfg_req_in.wr && (cfg_req_in.addr == psx_regs_pkg::OFF_SLOT)
		&& dn_port;
	assign wr_dctl = cfg_req_in.wr && (cfg_req_in.addr == psx_regs_pkg::OFF_DEV_CTL2);
	// Byte enables gate the one-bits that clear flags
	assign w1c = cfg_req_in.wdata & {{8{cfg_req_in.be[3]}}, {8{cfg_req_in.be[2]}},
		{8{cfg_req_in.be[1]}}, {8{cfg_req_in.be[0]}}};

	// ------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------
	psx_regs_pkg::psx_flags_t flags_ff;
	logic                     pres_seen_ff;
	logic                     link_seen_ff;
	logic                     presence_ff;
	logic                     strap_done_ff;
	logic                     pres_change;
	logic                     link_change;

	assign pres_change = strap_done_ff && (card_present_in != pres_seen_ff);
	assign link_change = strap_done_ff && (link_active_in != link_seen_ff);

	// One flag cell per event; clears only on a slot write
	psx_w1c_flag u_flag_button (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.clk_en_in (clk_en_in),
		.set_in    (button_event_in),
		.clear_in  (wr_slot && w1c[psx_regs_pkg::B_BUTTON]),
		.flag_out  (flags_ff.button)
	);

	psx_w1c_flag u_flag_pwr_fault (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.clk_en_in (clk_en_in),
		.set_in    (pwr_fault_event_in),
		.clear_in  (wr_slot && w1c[psx_regs_pkg::B_PWR_FAULT]),
		.flag_out  (flags_ff.pwr_fault)
	);

	psx_w1c_flag u_flag_pres_chg (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.clk_en_in (clk_en_in),
		.set_in    (pres_change),
		.clear_in  (wr_slot && w1c[psx_regs_pkg::B_PRES_CHG]),
		.flag_out  (flags_ff.pres_chg)
	);

	psx_w1c_flag u_flag_cmd_done (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.clk_en_in (clk_en_in),
		.set_in    (cmd_done_event_in),
		.clear_in  (wr_slot && w1c[psx_regs_pkg::B_CMD_DONE]),
		.flag_out  (flags_ff.cmd_done)
	);

	psx_w1c_flag u_flag_link_chg (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.clk_en_in (clk_en_in),
		.set_in    (link_change),
		.clear_in  (wr_slot && w1c[psx_regs_pkg::B_LINK_CHG]),
		.flag_out  (flags_ff.link_chg)
	);

	// ------------------------------------------------------------
	// Presence and link tracking
	// ------------------------------------------------------------
	// Strap is caught on the first enabled edge after release, never under reset
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			strap_done_ff <= 1'b0;
			presence_ff   <= 1'b0;
			pres_seen_ff  <= 1'b0;
			link_seen_ff  <= 1'b0;
		end else if (clk_en_in) begin
			strap_done_ff <= 1'b1;
			link_seen_ff  <= link_active_in;
			if (!strap_done_ff) begin
				presence_ff  <= ~presence_strap_in;
				pres_seen_ff <= card_present_in;
			end else begin
				presence_ff  <= card_present_in;
				pres_seen_ff <= card_present_in;
			end
		end
	end

	// ------------------------------------------------------------
	// Device control 2
	// ------------------------------------------------------------
	logic       ltr_en_ff;
	logic [1:0] obff_en_ff;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ltr_en_ff  <= 1'b0;
			obff_en_ff <= 2'h0;
		end else if (clk_en_in && wr_dctl) begin
			if (cfg_req_in.be[1]) begin
				ltr_en_ff  <= cfg_req_in.wdata[psx_regs_pkg::B_LTR_EN];
				obff_en_ff <= cfg_req_in.wdata[psx_regs_pkg::B_OBFF_EN_LO +: 2];
			end
		end
	end
	assign ltr_en_out  = ltr_en_ff;
	assign obff_en_out = obff_en_ff;

	// ------------------------------------------------------------
	// Read words
	// ------------------------------------------------------------
	logic [31:0] slot_word;
	logic [31:0] dcap_word;
	logic [31:0] dctl_word;
	logic [31:0] lctl_word;
	logic [31:0] nxt_rdata;
	logic        pres_bit;

	// Without a slot the presence bit is forced to one
	// Before the strap is caught the bit shows its reset value
	assign pres_bit = slot_impl_in ? (strap_done_ff ? presence_ff : ~presence_strap_in)
		: 1'b1;

	always_comb begin
		slot_word = psx_regs_pkg::ZERO_WORD;
		slot_word[15:0]                            = slot_ctrl_in;
		slot_word[psx_regs_pkg::B_BUTTON]          = flags_ff.button;
		slot_word[psx_regs_pkg::B_PWR_FAULT]       = flags_ff.pwr_fault;
		slot_word[psx_regs_pkg::B_LATCH_CHG]       = 1'b0;
		slot_word[psx_regs_pkg::B_PRES_CHG]        = flags_ff.pres_chg;
		slot_word[psx_regs_pkg::B_CMD_DONE]        = flags_ff.cmd_done;
		slot_word[psx_regs_pkg::B_LATCH_STATE]     = retention_latch_open_in;
		slot_word[psx_regs_pkg::B_PRESENCE]        = pres_bit;
		slot_word[psx_regs_pkg::B_LINK_CHG]        = flags_ff.link_chg;
	end

	always_comb begin
		dcap_word = psx_regs_pkg::ZERO_WORD;
		dcap_word[psx_regs_pkg::B_LTR_SUPP] = 1'b1;
		dcap_word[psx_regs_pkg::B_OBFF_SUPP_LO +: 2] = psx_regs_pkg::OBFF_SUPP_RST;
		dctl_word = psx_regs_pkg::ZERO_WORD;
		dctl_word[psx_regs_pkg::B_LTR_EN]          = ltr_en_ff;
		dctl_word[psx_regs_pkg::B_OBFF_EN_LO +: 2] = obff_en_ff;
		lctl_word = psx_regs_pkg::ZERO_WORD;
		lctl_word[psx_regs_pkg::B_SEL_DEEMP] = dn_port;
		lctl_word[psx_regs_pkg::B_CUR_DEEMP] = dn_port;
	end

	always_comb begin
		case (cfg_req_in.addr)
			psx_regs_pkg::OFF_SLOT:      nxt_rdata = dn_port ? slot_word
				: psx_regs_pkg::ZERO_WORD;
			psx_regs_pkg::OFF_DEV_CAP2:  nxt_rdata = dcap_word;
			psx_regs_pkg::OFF_DEV_CTL2:  nxt_rdata = dctl_word;
			psx_regs_pkg::OFF_LINK_CTL2: nxt_rdata = lctl_word;
			default:                     nxt_rdata = psx_regs_pkg::ZERO_WORD;
		endcase
	end

	// Read data is registered: one cycle of latency
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cfg_rdata_out  <= psx_regs_pkg::ZERO_WORD;
			cfg_rvalid_out <= 1'b0;
		end else if (clk_en_in) begin
			cfg_rvalid_out <= cfg_req_in.rd;
			if (cfg_req_in.rd) begin
				cfg_rdata_out <= nxt_rdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Hot-plug interrupt
	// ------------------------------------------------------------
	logic any_enabled;
	logic hp_int_ff;
	assign any_enabled =
		(flags_ff.button    && slot_ctrl_in[psx_regs_pkg::C_BUTTON_EN])    ||
		(flags_ff.pwr_fault && slot_ctrl_in[psx_regs_pkg::C_PWR_FAULT_EN]) ||
		(flags_ff.pres_chg  && slot_ctrl_in[psx_regs_pkg::C_PRES_CHG_EN])  ||
		(flags_ff.cmd_done  && slot_ctrl_in[psx_regs_pkg::C_CMD_DONE_EN])  ||
		(flags_ff.link_chg  && slot_ctrl_in[psx_regs_pkg::C_LINK_CHG_EN]);
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			hp_int_ff <= 1'b0;
		end else if (clk_en_in) begin
			hp_int_ff <= dn_port && any_enabled
				&& slot_ctrl_in[psx_regs_pkg::C_HP_INT_EN];
		end
	end
	assign hp_int_out = hp_int_ff;
endmodule

// ------------------------------------------------------------
// One write-one-to-clear event flag
// ------------------------------------------------------------
module psx_w1c_flag (
	input  wire logic clk_in,
	input  wire logic reset_in,
	input  wire logic clk_en_in,
	input  wire logic set_in,
	input  wire logic clear_in,
	output logic      flag_out
);
	logic flag_ff;
	logic nxt_flag;

	// Set wins over a clear in the same cycle, so no event is lost
	always_comb begin
		nxt_flag = flag_ff;
		if (clear_in) begin
			nxt_flag = 1'b0;
		end
		if (set_in) begin
			nxt_flag = 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			flag_ff <= 1'b0;
		end else if (clk_en_in) begin
			flag_ff <= nxt_flag;
		end
	end

	assign flag_out = flag_ff;
endmodule
`default_nettype wire

/* logic/psx_regs_pkg.sv */
// Package: offsets, field positions and reset values for the slot status / cap-2 register bank
`default_nettype none
package psx_regs_pkg;
	localparam int          ADDR_W            = 8;
	localparam logic [7:0]  OFF_SLOT          = 8'hD8;
	localparam logic [7:0]  OFF_DEV_CAP2      = 8'hE4;
	localparam logic [7:0]  OFF_DEV_CTL2      = 8'hE8;
	localparam logic [7:0]  OFF_LINK_CAP2     = 8'hEC;
	localparam logic [7:0]  OFF_LINK_CTL2     = 8'hF0;
	localparam logic [7:0]  OFF_SLOT_CAP2     = 8'hF4;
	localparam logic [7:0]  OFF_SLOT_CTL2     = 8'hF8;
	// Slot status bits within the D8h dword
	localparam int          B_BUTTON          = 16;
	localparam int          B_PWR_FAULT       = 17;
	localparam int          B_LATCH_CHG       = 18;
	localparam int          B_PRES_CHG        = 19;
	localparam int          B_CMD_DONE        = 20;
	localparam int          B_LATCH_STATE     = 21;
	localparam int          B_PRESENCE        = 22;
	localparam int          B_LINK_CHG        = 24;
	// Slot control bits (lower half of D8h, held outside this block)
	localparam int          C_BUTTON_EN       = 0;
	localparam int          C_PWR_FAULT_EN    = 1;
	localparam int          C_PRES_CHG_EN     = 3;
	localparam int          C_CMD_DONE_EN     = 4;
	localparam int          C_HP_INT_EN       = 5;
	localparam int          C_LINK_CHG_EN     = 12;
	// Capability / control 2 fields
	localparam int          B_LTR_SUPP        = 11;
	localparam int          B_OBFF_SUPP_LO    = 18;
	localparam logic [1:0]  OBFF_SUPP_RST     = 2'h1;
	localparam int          B_LTR_EN          = 10;
	localparam int          B_OBFF_EN_LO      = 13;
	localparam int          B_SEL_DEEMP       = 6;
	localparam int          B_CUR_DEEMP       = 16;
	localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;

	typedef struct packed {
		logic button;
		logic pwr_fault;
		logic pres_chg;
		logic cmd_done;
		logic link_chg;
	} psx_flags_t;

	typedef struct packed {
		logic                 rd;
		logic                 wr;
		logic [ADDR_W-1:0]    addr;
		logic [31:0]          wdata;
		logic [3:0]           be;
	} psx_cfg_req_t;
endpackage
`default_nettype wire

/* test/psx_slot_regs_chk.sv */
// Checker for the slot status and capability 2 register bank
`default_nettype none
module psx_slot_regs_chk (
	input wire logic                       clk_in,
	input wire logic                       reset_in,
	input wire logic                       clk_en_in,
	input wire logic                       downstream_in,
	input wire logic [15:0]                slot_ctrl_in,
	input wire psx_regs_pkg::psx_cfg_req_t cfg_req_in,
	input wire logic [31:0]                cfg_rdata_out,
	input wire logic                       cfg_rvalid_out,
	input wire logic                       ltr_en_out,
	input wire logic [1:0]                 obff_en_out,
	input wire logic                       hp_int_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	wire logic       rd = cfg_req_in.rd && clk_en_in;
	wire logic [7:0] a  = cfg_req_in.addr;
	chk_read_answer: assert property (rd |=> cfg_rvalid_out)
		else $error("read not answered");
	chk_no_spurious: assert property (clk_en_in && !cfg_req_in.rd |=> !cfg_rvalid_out)
		else $error("answer without read");
	chk_cap2_value: assert property (rd && a == 8'hE4 |=> cfg_rdata_out == 32'h0004_0800)
		else $error("capability 2 word wrong");
	chk_zero_words: assert property (rd && a inside {8'hEC, 8'hF4, 8'hF8} |=> cfg_rdata_out == 0)
		else $error("empty word not zero");
	chk_upstream_slot: assert property (rd && a == 8'hD8 && !downstream_in |=> cfg_rdata_out == 0)
		else $error("slot word seen upstream");
	chk_slot_fixed: assert property (rd && a == 8'hD8 && downstream_in |=>
		cfg_rdata_out[15:0] == $past(slot_ctrl_in) && !cfg_rdata_out[18] && !cfg_rdata_out[23]
		&& cfg_rdata_out[31:25] == 0) else $error("slot word fixed bits wrong");
	chk_deemp_level: assert property (rd && a == 8'hF0 |=>
		cfg_rdata_out == {15'h0, $past(downstream_in), 9'h0, $past(downstream_in), 6'h0})
		else $error("de-emphasis bits wrong");
	chk_int_gate: assert property ((!slot_ctrl_in[5] || !downstream_in) && clk_en_in |=> !hp_int_out)
		else $error("interrupt without global enable");
	chk_ctl2_write: assert property (cfg_req_in.wr && clk_en_in && a == 8'hE8 && cfg_req_in.be[1] |=>
		ltr_en_out == $past(cfg_req_in.wdata[10]) && obff_en_out == $past(cfg_req_in.wdata[14:13]))
		else $error("control 2 enables not written");
endmodule
bind psx_slot_regs psx_slot_regs_chk u_chk (.clk_in(clk_in), .reset_in(reset_in),
	.clk_en_in(clk_en_in), .downstream_in(downstream_in), .slot_ctrl_in(slot_ctrl_in),
	.cfg_req_in(cfg_req_in), .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
	.ltr_en_out(ltr_en_out), .obff_en_out(obff_en_out), .hp_int_out(hp_int_out));
`default_nettype wire

/* test/psx_slot_regs_test.sv */
// Self-checking testbench for the slot status and capability 2 register bank
`default_nettype none
module psx_slot_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, reset_in, ds, impl, strap, card, latch, btn, pwr, cmd, link, en;
	logic [15:0] ctrl;
	psx_regs_pkg::psx_cfg_req_t req;
	logic [31:0] rdata;
	logic rvalid, ltr, irq;
	logic [1:0] obff;
	int n_errors = 0;
	int comparisons = 0;
	logic [7:0]  r_addr[8] = '{8'hD8, 8'hE4, 8'hE8, 8'hEC, 8'hF0, 8'hF4, 8'hF8, 8'h10};
	logic [31:0] r_exp[8]  = '{32'h0040_0000, 32'h0004_0800, 32'h0, 32'h0, 32'h0001_0040,
		32'h0, 32'h0, 32'h0};
	psx_slot_regs u_dut (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(en),
		.downstream_in(ds), .slot_impl_in(impl), .presence_strap_in(strap),
		.card_present_in(card), .retention_latch_open_in(latch), .button_event_in(btn),
		.pwr_fault_event_in(pwr), .cmd_done_event_in(cmd), .link_active_in(link),
		.slot_ctrl_in(ctrl), .cfg_req_in(req), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
		.ltr_en_out(ltr), .obff_en_out(obff), .hp_int_out(irq));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge clk_in);
		req.rd = 1'b0;
		chk("rvalid", 32'h1, {31'h0, rvalid});
		chk("rdata", exp, rdata);
		@(negedge clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge clk_in);
		req.wr = 1'b0;
		@(negedge clk_in);
	endtask
	task automatic do_reset();
		reset_in = 1'b1;
		repeat (10) @(negedge clk_in);
		reset_in = 1'b0;
		repeat (3) @(negedge clk_in);
	endtask
	initial begin
		#20000;
		n_errors++;
		end_sim();
	end
	initial begin
		{ds, impl, strap, card, latch, btn, pwr, cmd, link} = 9'h1A0;
		en = 1'b1;
		ctrl = 16'h0;
		req = '0;
		req.be = 4'hF;
		do_reset();
		for (int i = 0; i < 8; i++)
			rdc(r_addr[i], r_exp[i]);
		// ---------------------------------------------------------------
		// Events, write-one-to-clear and read-only bits
		// ---------------------------------------------------------------
		{btn, pwr, cmd} = 3'h7;
		@(negedge clk_in);
		{btn, pwr, cmd, link, card, latch} = 6'h05;
		repeat (2) @(negedge clk_in);
		rdc(8'hD8, 32'h013B_0000);
		wr(8'hD8, 32'h0001_0000);
		rdc(8'hD8, 32'h013A_0000);
		wr(8'hD8, 32'h01FF_0000);
		rdc(8'hD8, 32'h0020_0000);
		// ---------------------------------------------------------------
		// Interrupt gating; the interrupt must drop when the global enable is cleared
		// ---------------------------------------------------------------
		ctrl = 16'h0021;
		btn = 1'b1;
		@(negedge clk_in);
		btn = 1'b0;
		for (int i = 0; i < 4 && irq !== 1'b1; i++)
			@(negedge clk_in);
		chk("hp_int", 32'h1, {31'h0, irq});
		rdc(8'hD8, 32'h0021_0021);
		ctrl = 16'h0001;
		repeat (2) @(negedge clk_in);
		chk("hp_int", 32'h0, {31'h0, irq});
		wr(8'hD8, 32'h0001_0000);
		// ---------------------------------------------------------------
		// Control 2 fields and writes to read-only words
		// ---------------------------------------------------------------
		wr(8'hE8, 32'hFFFF_FFFF);
		rdc(8'hE8, 32'h0000_6400);
		chk("enables", 32'h7, {29'h0, ltr, obff});
		// Clock enable low: no write lands, no event is caught
		{en, btn} = 2'h1;
		wr(8'hE8, 32'h0);
		{en, btn} = 2'h2;
		chk("enables", 32'h7, {29'h0, ltr, obff});
		rdc(8'hD8, 32'h0020_0001);
		wr(8'hE4, 32'hFFFF_FFFF);
		rdc(8'hE4, 32'h0004_0800);
		// Slot not implemented: presence forced high with no card
		ctrl = 16'h0;
		{impl, card, latch} = 3'h0;
		do_reset();
		rdc(8'hD8, 32'h0040_0000);
		// Presence shows the strap's reset value before the card is seen
		{impl, strap, card} = 3'h7;
		reset_in = 1'b1;
		repeat (10) @(negedge clk_in);
		reset_in = 1'b0;
		req.rd = 1'b1;
		req.addr = 8'hD8;
		@(negedge clk_in);
		req.rd = 1'b0;
		chk("rdata", 32'h0, rdata);
		@(negedge clk_in);
		rdc(8'hD8, 32'h0040_0000);
		// Upstream port hides the slot word and clears de-emphasis
		{ds, impl} = 2'h1;
		do_reset();
		rdc(8'hD8, 32'h0);
		rdc(8'hF0, 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
